// [shared/cscf_pkg.sv]
// Constants shared by the card status-change flag logic
`default_nettype none
package cscf_pkg;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 8;
    localparam int          NUM_SRC     = 4;
    // Register offsets within the socket register space
    localparam logic [11:0] FLAGS_OFS   = 12'h804;
    localparam logic [11:0] CFG_OFS     = 12'h805;
    // Flag and enable bit positions, shared by both registers
    localparam int          CD_BIT      = 3;
    localparam int          RDY_BIT     = 2;
    localparam int          LOW_BIT     = 1;
    localparam int          DEAD_BIT    = 0;
    // Line select field of the configuration register
    localparam int          SEL_LSB     = 4;
    localparam int          SEL_W       = 4;
    // Reset values
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;
    localparam logic [7:0]  RDATA_RESET = 8'h00;
    // Positions of the card-side inputs in the synchroniser vector
    localparam int          IN_CDA      = 0;
    localparam int          IN_CDB      = 1;
    localparam int          IN_RDY      = 2;
    localparam int          IN_LOW      = 3;
    localparam int          IN_DEAD     = 4;
    localparam int          IN_RING     = 5;
    localparam int          SYNC_W      = 6;
endpackage : cscf_pkg
`default_nettype wire

// [hw/cscf_sync.sv]
// Two-flop synchroniser for a vector of independent card-side levels
`timescale 1ns/10ps
`default_nettype none
module cscf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] asyncIn,
    output var  logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : cscf_sync
`default_nettype wire

// [hw/cscf_flags.sv]
// Card status-change flags, their configuration register and request output
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Bits 7 to 4 of the status-change register read as zero and ignore writes.
// - A change on either card-detect input sets the card-detect change flag.
// - Each flag is cleared by a read of the register or by writing a one to its bit.
// - With a memory card, a low-to-high edge of ready sets the ready-rise flag.
// - With an I/O card, the ready-rise and low-charge flags stay at zero.
// - With a memory card, a low-battery warning sets the low-charge flag.
// - Bit 0 latches battery dead on a memory card and status-change assertion on an I/O card.
// - With ring indicate and the dead-cell enable bit both set, bit 0 reads the current level of the ring pin.
// - A read/write configuration register resetting to zero masks sources and picks routing.
// - A flag whose source is disabled reads zero, except in the first cycle after the disabling write.
// - The clear mode select chooses clear-on-read or clear on write of one.
// - The low four configuration bits enable card detect, ready, low charge and dead cell.
// - The upper four configuration bits select the line for status-change requests.
module cscf_flags (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         cardDetectPinA,
    input  wire logic                         cardDetectPinB,
    input  wire logic                         cardReadyPin,
    input  wire logic                         lowChargePin,
    input  wire logic                         cardStatusChangePin,
    input  wire logic                         phoneLineAlertPin,
    input  wire logic                         ioCardInstalled,
    input  wire logic                         ringEnable,
    input  wire logic                         clearOnWriteMode,
    input  wire logic [cscf_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic                         regRead,
    input  wire logic                         regWrite,
    input  wire logic [cscf_pkg::DATA_W-1:0]  regWrData,
    output var  logic [cscf_pkg::DATA_W-1:0]  regRdData,
    output var  logic                         regRdValid,
    output var  logic                         cardEventIrq,
    output var  logic [cscf_pkg::SEL_W-1:0]   cardEventLineSelect
);
    logic [cscf_pkg::SYNC_W-1:0]  inSync;
    logic [cscf_pkg::SYNC_W-1:0]  inPrev_q;
    logic [cscf_pkg::SYNC_W-1:0]  inPrev_d;
    logic [cscf_pkg::NUM_SRC-1:0] flags_q;
    logic [cscf_pkg::NUM_SRC-1:0] flags_d;
    logic [cscf_pkg::DATA_W-1:0]  cfg_q;
    logic [cscf_pkg::DATA_W-1:0]  cfg_d;
    logic [cscf_pkg::DATA_W-1:0]  rdData_d;
    logic                         rdValid_d;
    logic                         irq_d;
    logic [cscf_pkg::SEL_W-1:0]   lineSel_d;
    logic [cscf_pkg::NUM_SRC-1:0] events;
    logic [cscf_pkg::NUM_SRC-1:0] clears;
    logic                         readFlags;
    logic                         writeFlags;
    logic                         readCfg;
    logic                         writeCfg;
    logic [cscf_pkg::DATA_W-1:0]  flagsView;

    cscf_sync #(
        .W (cscf_pkg::SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({phoneLineAlertPin, cardStatusChangePin, lowChargePin,
                   cardReadyPin, cardDetectPinB, cardDetectPinA}),
        .syncOut (inSync)
    );

    assign readFlags  = regRead && (regAddr == cscf_pkg::FLAGS_OFS);
    assign writeFlags = regWrite && (regAddr == cscf_pkg::FLAGS_OFS);
    assign readCfg    = regRead && (regAddr == cscf_pkg::CFG_OFS);
    assign writeCfg   = regWrite && (regAddr == cscf_pkg::CFG_OFS);

    // Edge detector on the synchronised card levels
    always_comb begin
        inPrev_d = inSync;
        events   = '0;
        // Either detect line toggling counts as one change
        events[cscf_pkg::CD_BIT]   = (inSync[cscf_pkg::IN_CDA] ^ inPrev_q[cscf_pkg::IN_CDA])
                                   | (inSync[cscf_pkg::IN_CDB] ^ inPrev_q[cscf_pkg::IN_CDB]);
        events[cscf_pkg::RDY_BIT]  = inSync[cscf_pkg::IN_RDY] & ~inPrev_q[cscf_pkg::IN_RDY];
        events[cscf_pkg::LOW_BIT]  = inSync[cscf_pkg::IN_LOW] & ~inPrev_q[cscf_pkg::IN_LOW];
        // Same pin carries battery dead or status change, by card type
        events[cscf_pkg::DEAD_BIT] = inSync[cscf_pkg::IN_DEAD] & ~inPrev_q[cscf_pkg::IN_DEAD];
    end

    // Stored flags
    always_comb begin
        clears = '0;
        if (readFlags && !clearOnWriteMode) begin
            clears = '1;
        end
        if (writeFlags && clearOnWriteMode) begin
            clears = regWrData[cscf_pkg::NUM_SRC-1:0];
        end

        // Set wins over clear; a source disabled in cfg_q holds no flag from the next edge
        flags_d = (events | (flags_q & ~clears)) & cfg_q[cscf_pkg::NUM_SRC-1:0];
        if (ioCardInstalled) begin
            flags_d[cscf_pkg::RDY_BIT] = 1'b0;
            flags_d[cscf_pkg::LOW_BIT] = 1'b0;
        end
    end

    // Configuration register and its routing copy
    always_comb begin
        cfg_d     = writeCfg ? regWrData : cfg_q;
        lineSel_d = cfg_d[cscf_pkg::SEL_LSB +: cscf_pkg::SEL_W];
    end

    // Read port
    always_comb begin
        flagsView = {{(cscf_pkg::DATA_W-cscf_pkg::NUM_SRC){1'b0}}, flags_q};
        if (ringEnable) begin
            flagsView[cscf_pkg::DEAD_BIT] = inSync[cscf_pkg::IN_RING]
                                          & cfg_q[cscf_pkg::DEAD_BIT];
        end

        rdValid_d = regRead;
        // Unmapped reads return zero
        rdData_d  = cscf_pkg::RDATA_RESET;
        if (readFlags) begin
            rdData_d = flagsView;
        end else if (readCfg) begin
            rdData_d = cfg_q;
        end
    end

    // Request follows the stored flags, which are already masked
    always_comb begin
        irq_d = |flags_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inPrev_q <= '0;
        end else begin
            inPrev_q <= inPrev_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= cscf_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q               <= cscf_pkg::CFG_RESET;
            cardEventLineSelect <= '0;
        end else begin
            cfg_q               <= cfg_d;
            cardEventLineSelect <= lineSel_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData  <= cscf_pkg::RDATA_RESET;
            regRdValid <= 1'b0;
        end else begin
            regRdData  <= rdData_d;
            regRdValid <= rdValid_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cardEventIrq <= 1'b0;
        end else begin
            cardEventIrq <= irq_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_upper_bits_zero: assert property (
        $past(readFlags) |-> regRdValid && regRdData[7:4] == 4'h0)
        else $error("upper status bits not zero on read");

    a_cd_change_set: assert property (
        (events[cscf_pkg::CD_BIT] && cfg_q[cscf_pkg::CD_BIT] && !writeCfg)
        |=> flags_q[cscf_pkg::CD_BIT])
        else $error("card detect change not latched");

    a_read_clears: assert property (
        (readFlags && !clearOnWriteMode && !events[cscf_pkg::CD_BIT])
        |=> !flags_q[cscf_pkg::CD_BIT])
        else $error("read did not clear flag");

    a_write_one_clears: assert property (
        (writeFlags && clearOnWriteMode && regWrData[cscf_pkg::RDY_BIT]
         && !events[cscf_pkg::RDY_BIT]) |=> !flags_q[cscf_pkg::RDY_BIT])
        else $error("write of one did not clear flag");

    a_ready_rise_set: assert property (
        (events[cscf_pkg::RDY_BIT] && !ioCardInstalled && cfg_q[cscf_pkg::RDY_BIT]
         && !writeCfg) |=> flags_q[cscf_pkg::RDY_BIT])
        else $error("ready rise not latched");

    a_io_card_zero: assert property (
        ioCardInstalled && $past(ioCardInstalled)
        |-> !flags_q[cscf_pkg::RDY_BIT] && !flags_q[cscf_pkg::LOW_BIT])
        else $error("ready or low charge flag set with I/O card");

    a_mask_zero: assert property (
        ##1 (flags_q & ~$past(cfg_q[cscf_pkg::NUM_SRC-1:0])) == 4'h0)
        else $error("disabled source holds a flag");

    a_ring_level: assert property (
        (readFlags && ringEnable && cfg_q[cscf_pkg::DEAD_BIT])
        |=> regRdData[cscf_pkg::DEAD_BIT] == $past(inSync[cscf_pkg::IN_RING]))
        else $error("ring level not reported");

    a_cfg_write: assert property (
        writeCfg |=> cfg_q == $past(regWrData)
                     && cardEventLineSelect == $past(regWrData[7:4]))
        else $error("configuration write not stored");

    a_irq_follows: assert property (
        (|flags_q) |=> cardEventIrq)
        else $error("request missing while flag set");

    a_irq_drops: assert property (
        (flags_q == 4'h0) |=> !cardEventIrq)
        else $error("request held with no flag set");

    c_cd_irq:    cover property (events[cscf_pkg::CD_BIT] && cfg_q[cscf_pkg::CD_BIT] ##2 cardEventIrq);
    c_read_clr:  cover property (flags_q != 4'h0 && readFlags && !clearOnWriteMode ##1 flags_q == 4'h0);
    c_w1c:       cover property (writeFlags && clearOnWriteMode && flags_q != 4'h0);
    c_ring_read: cover property (readFlags && ringEnable && inSync[cscf_pkg::IN_RING]);
endmodule : cscf_flags
`default_nettype wire

// [test/cscf_card_model.sv]
// Card-side pin model for the status-change flag bench
`timescale 1ns/10ps
`default_nettype none
module cscf_card_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [5:0] toggleReq,
    output var  logic [5:0] pins
);
    // Pins are held levels; a card never pulses them for us
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins <= 6'h00;
        end else begin
            pins <= pins ^ toggleReq;
        end
    end
endmodule : cscf_card_model
`default_nettype wire

// [test/card_status_change_flags_test.sv]
// Self-checking bench for the card status-change flags
`timescale 1ns/10ps
`default_nettype none
module card_status_change_flags_test;
    logic        clk;
    logic        rst_b;
    logic        io;
    logic        ring;
    logic        wclr;
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic        rvld;
    logic        irq;
    logic [3:0]  sel;
    logic [5:0]  tog;
    logic [5:0]  pins;
    int          n_fail;
    int          check_count;
    int          cyc;

    cscf_card_model u_cscf_card_model (.clk(clk), .rst_b(rst_b), .toggleReq(tog), .pins(pins));
    cscf_flags u_cscf_flags (.clk(clk), .rst_b(rst_b), .cardDetectPinA(pins[0]),
        .cardDetectPinB(pins[1]), .cardReadyPin(pins[2]), .lowChargePin(pins[3]),
        .cardStatusChangePin(pins[4]), .phoneLineAlertPin(pins[5]), .ioCardInstalled(io),
        .ringEnable(ring), .clearOnWriteMode(wclr), .regAddr(addr), .regRead(rd),
        .regWrite(wr), .regWrData(wdat), .regRdData(rdat), .regRdValid(rvld),
        .cardEventIrq(irq), .cardEventLineSelect(sel));

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({7'h00, rvld}, 8'h01);
        chk(rdat, exp);
    endtask : rreg

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg

    // Pin change must outlive the synchroniser and edge detector
    task automatic pulse(input int idx);
        @(negedge clk);
        tog = 6'h01 << idx;
        @(negedge clk);
        tog = 6'h00;
        repeat (6) @(negedge clk);
    endtask : pulse

    task automatic t_cfg;
        rreg(12'h805, 8'h00);
        rreg(12'h804, 8'h00);
        rreg(12'h7ff, 8'h00);
        wreg(12'h805, 8'ha5);
        rreg(12'h805, 8'ha5);
        chk({4'h0, sel}, 8'h0a);
        wreg(12'h804, 8'hff);
        rreg(12'h804, 8'h00);
        wreg(12'h805, 8'h0f);
    endtask : t_cfg

    task automatic t_events;
        int pinIdx[4] = '{0, 2, 3, 4};
        for (int i = 0; i < 4; i++) begin
            pulse(pinIdx[i]);
            chk({7'h00, irq}, 8'h01);
            rreg(12'h804, 8'h08 >> i);
            rreg(12'h804, 8'h00);
            repeat (2) @(negedge clk);
            chk({7'h00, irq}, 8'h00);
        end
    endtask : t_events

    task automatic t_io;
        io = 1'b1;
        pulse(2);
        pulse(2);
        pulse(3);
        pulse(3);
        rreg(12'h804, 8'h00);
        pulse(4);
        pulse(4);
        rreg(12'h804, 8'h01);
        wreg(12'h805, 8'h07);
        pulse(1);
        rreg(12'h804, 8'h00);
        io = 1'b0;
    endtask : t_io

    task automatic t_wclr;
        wreg(12'h805, 8'h0f);
        wclr = 1'b1;
        pulse(1);
        rreg(12'h804, 8'h08);
        rreg(12'h804, 8'h08);
        wreg(12'h804, 8'h08);
        rreg(12'h804, 8'h00);
    endtask : t_wclr

    task automatic t_ring;
        ring = 1'b1;
        pulse(5);
        rreg(12'h804, 8'h01);
        pulse(5);
        rreg(12'h804, 8'h00);
    endtask : t_ring

    // Event and read-clear in one cycle: the set must survive
    task automatic t_race;
        wclr = 1'b0;
        ring = 1'b0;
        @(negedge clk);
        tog = 6'h01;
        @(negedge clk);
        tog = 6'h00;
        @(negedge clk);
        @(negedge clk);
        addr = 12'h804;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdat, 8'h00);
        rreg(12'h804, 8'h08);
        rreg(12'h804, 8'h00);
    endtask : t_race

    // Mid-run reset must drop stored state and the request
    task automatic t_reset;
        wreg(12'h805, 8'hf8);
        pulse(0);
        chk({7'h00, irq}, 8'h01);
        chk({4'h0, sel}, 8'h0f);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk({7'h00, irq}, 8'h00);
        chk({4'h0, sel}, 8'h00);
        rreg(12'h805, 8'h00);
        rreg(12'h804, 8'h00);
    endtask : t_reset

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Run needs a few hundred cycles; hang guard well above that
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        {io, ring, wclr, rd, wr, tog, wdat, addr} = '0;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        rst_b = 1'b0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_cfg();
        t_events();
        t_io();
        t_wclr();
        t_ring();
        t_race();
        t_reset();
        end_sim();
    end
endmodule : card_status_change_flags_test
`default_nettype wire
